/* File: rtl/vga_gfx_attr_dac_regs.sv */
/*
  Host I/O register bank for the graphics controller, attribute controller
  and palette (colour lookup) ports, plus the small pixel paths that use
  the attribute palette, padding bits and palette pixel mask.
  Assumes host port cycles are synchronous one-cycle strobes on i_clk and
  that the display datapath consumes the decoded fields.
*/
`timescale 1ns/1ns
// Operation
// - compare colour: 4-bit reference, upper bits reserved
// - don't-care: 4 planes join colour compare
// - rotate count: 3-bit right rotate
// - logic function: 2-bit select
// - read plane: 2-bit plane for reads
// - write mode 2 bits, compare-read bit
// - odd/even addressing, odd/even shift, 256 shift
// - memory map: graphics, chain, window select
// - bit mask: eight per-bit write masks
// - attribute index 5 bits, video enable bit
// - attribute data; sixteen 6-bit palette entries
// - attribute mode bits; bit 4 reserved
// - mode bit 7 sources output bits 5-4
// - padding bits 3-2 drive output bits 7-6
// - horizontal pan: 4-bit left shift
// - plane enables and status select field
// - read index port write-only; reads give status
// - status tells last palette cycle direction
// - write index port; reads return index
// - data port accesses indexed palette entry
module vga_gfx_attr_dac_regs
  import vga_regs_pkg::*;
#(
  parameter int PAL_IDX_W = PAL_INDEX_BITS
)
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // host i/o port
  input wire logic [15:0] i_io_addr,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [7:0] i_io_wdata,
  output logic [7:0] o_io_rdata,
  output logic o_io_rdata_valid,
  // pixel inputs
  input wire logic [3:0] i_pixel_attr,
  input wire logic [7:0] i_dac_pixel,
  // graphics controller fields
  output logic [3:0] o_compare_color,
  output logic [3:0] o_compare_dont_care,
  output logic [2:0] o_rotate_count,
  output logic [1:0] o_logic_function,
  output logic [1:0] o_read_plane,
  output logic [1:0] o_write_mode,
  output logic o_read_compare_en,
  output logic o_odd_even_addr,
  output logic o_shift_odd_even,
  output logic o_shift_256,
  output logic o_graphics_addr,
  output logic o_chain_odd_even,
  output logic [1:0] o_memory_map,
  output logic [7:0] o_write_bit_mask,
  // attribute controller fields
  output logic o_video_enable,
  output logic o_attr_graphics,
  output logic o_attr_mono,
  output logic o_attr_line_graphics,
  output logic o_attr_blink,
  output logic o_attr_top_pan,
  output logic o_attr_256_color,
  output logic [7:0] o_border_color,
  output logic [3:0] o_plane_enable,
  output logic [1:0] o_status_select,
  output logic [3:0] o_pixel_pan,
  // pixel outputs
  output logic [7:0] o_video_index,
  output logic [3*PAL_COMP_BITS-1:0] o_dac_color
);

  // ==========================================================================
  // state
  typedef struct packed {
    logic [7:0] rdata;
    logic rdata_valid;
    logic [3:0] gfx_index;
    logic [7:0] compare;
    logic [7:0] rotate;
    logic [7:0] read_plane;
    logic [7:0] gfx_mode;
    logic [7:0] mem_map;
    logic [7:0] dont_care;
    logic [7:0] bit_mask;
    logic [7:0] attr_index;
    logic attr_is_data;
    logic [15:0][7:0] attr_pal;
    logic [7:0] attr_mode;
    logic [7:0] border;
    logic [7:0] plane_en;
    logic [7:0] pan;
    logic [7:0] pad;
    logic [7:0] video_index;
    logic [7:0] pal_mask;
    logic [7:0] pal_rindex;
    logic [7:0] pal_windex;
    logic [1:0] pal_sub;
    logic [2*PAL_COMP_BITS-1:0] pal_wbuf;
    pal_cycle_type pal_last;
    logic [3*PAL_COMP_BITS-1:0] dac_color;
  } state_type;

  state_type s_r;
  state_type s_nxt;

  logic pal_wr_en;
  logic [3*PAL_COMP_BITS-1:0] pal_wr_color;
  logic [3*PAL_COMP_BITS-1:0] pal_host_color;
  logic [3*PAL_COMP_BITS-1:0] pal_pixel_color;

  // reserved bits are dropped on write so they always read back as zero
  function automatic logic [7:0] keep_bits(input logic [7:0] value, input logic [7:0] mask);
    keep_bits = value & mask;
  endfunction

  // one 6-bit component of a palette entry, red first
  function automatic logic [7:0] pick_comp(input logic [3*PAL_COMP_BITS-1:0] color, input logic [1:0] sel);
    logic [PAL_COMP_BITS-1:0] comp;
    case (sel)
      2'h0: comp = color[3*PAL_COMP_BITS-1:2*PAL_COMP_BITS];
      2'h1: comp = color[2*PAL_COMP_BITS-1:PAL_COMP_BITS];
      default: comp = color[PAL_COMP_BITS-1:0];
    endcase
    pick_comp = {2'h0, comp};
  endfunction

  // ==========================================================================
  // palette storage
  palette_store #(
    .IDX_W(PAL_IDX_W)
  ) u_palette (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_wr_en(pal_wr_en),
    .i_wr_index(s_r.pal_windex[PAL_IDX_W-1:0]),
    .i_wr_color(pal_wr_color),
    .i_host_index(s_r.pal_rindex[PAL_IDX_W-1:0]),
    .o_host_color(pal_host_color),
    .i_pixel_index(i_dac_pixel[PAL_IDX_W-1:0] & s_r.pal_mask[PAL_IDX_W-1:0]),
    .o_pixel_color(pal_pixel_color)
  );

  // ==========================================================================
  // next-state logic: host writes, host reads and pixel paths
  always_comb
  begin
    logic [7:0] attr_entry;
    attr_entry = '0;
    s_nxt = s_r;
    s_nxt.rdata_valid = 1'b0;
    pal_wr_en = 1'b0;
    pal_wr_color = {s_r.pal_wbuf, i_io_wdata[PAL_COMP_BITS-1:0]};

    // host writes
    if (i_io_wr)
    begin
      case (i_io_addr)
        PORT_GFX_INDEX: s_nxt.gfx_index = i_io_wdata[3:0];
        PORT_GFX_DATA:
        begin
          // data lands in whatever the index last selected
          case (s_r.gfx_index)
            GR_COMPARE: s_nxt.compare = keep_bits(i_io_wdata, MASK_COMPARE);
            GR_ROTATE: s_nxt.rotate = keep_bits(i_io_wdata, MASK_ROTATE);
            GR_READ_PLANE: s_nxt.read_plane = keep_bits(i_io_wdata, MASK_READ_PLANE);
            GR_MODE: s_nxt.gfx_mode = keep_bits(i_io_wdata, MASK_GFX_MODE);
            GR_MEM_MAP: s_nxt.mem_map = keep_bits(i_io_wdata, MASK_MEM_MAP);
            GR_DONT_CARE: s_nxt.dont_care = keep_bits(i_io_wdata, MASK_DONT_CARE);
            GR_BIT_MASK: s_nxt.bit_mask = keep_bits(i_io_wdata, MASK_BIT_MASK);
            default: ;
          endcase
        end
        PORT_ATTR_INDEX:
        begin
          // one port alternates between index and data writes
          s_nxt.attr_is_data = !s_r.attr_is_data;
          if (!s_r.attr_is_data)
          begin
            s_nxt.attr_index = keep_bits(i_io_wdata, MASK_ATTR_INDEX);
          end
          else if (s_r.attr_index[4:0] <= AR_PAL_LAST)
          begin
            s_nxt.attr_pal[s_r.attr_index[3:0]] = keep_bits(i_io_wdata, MASK_PALETTE);
          end
          else
          begin
            case (s_r.attr_index[4:0])
              AR_MODE: s_nxt.attr_mode = keep_bits(i_io_wdata, MASK_ATTR_MODE);
              AR_BORDER: s_nxt.border = keep_bits(i_io_wdata, MASK_BORDER);
              AR_PLANE_EN: s_nxt.plane_en = keep_bits(i_io_wdata, MASK_PLANE_EN);
              AR_PAN: s_nxt.pan = keep_bits(i_io_wdata, MASK_PAN);
              AR_PAD: s_nxt.pad = keep_bits(i_io_wdata, MASK_PAD);
              default: ;
            endcase
          end
        end
        PORT_PAL_MASK: s_nxt.pal_mask = i_io_wdata;
        PORT_PAL_RINDEX:
        begin
          // write-only index; restarts the component sequence
          s_nxt.pal_rindex = i_io_wdata;
          s_nxt.pal_sub = 2'h0;
          s_nxt.pal_last = PAL_CYCLE_READ;
        end
        PORT_PAL_WINDEX:
        begin
          s_nxt.pal_windex = i_io_wdata;
          s_nxt.pal_sub = 2'h0;
          s_nxt.pal_last = PAL_CYCLE_WRITE;
        end
        PORT_PAL_DATA:
        begin
          // entry written only on its third byte, so a partial entry never shows
          s_nxt.pal_last = PAL_CYCLE_WRITE;
          if (s_r.pal_sub == PAL_LAST_COMP)
          begin
            pal_wr_en = 1'b1;
            s_nxt.pal_windex = s_r.pal_windex + 8'h01;
            s_nxt.pal_sub = 2'h0;
          end
          else
          begin
            s_nxt.pal_wbuf = {s_r.pal_wbuf[PAL_COMP_BITS-1:0], i_io_wdata[PAL_COMP_BITS-1:0]};
            s_nxt.pal_sub = s_r.pal_sub + 2'h1;
          end
        end
        default: ;
      endcase
    end

    // host reads: answered one cycle later, unmapped ports read zero
    if (i_io_rd)
    begin
      s_nxt.rdata_valid = 1'b1;
      s_nxt.rdata = 8'h00;
      case (i_io_addr)
        PORT_GFX_INDEX: s_nxt.rdata = {4'h0, s_r.gfx_index};
        PORT_GFX_DATA:
        begin
          case (s_r.gfx_index)
            GR_COMPARE: s_nxt.rdata = s_r.compare;
            GR_ROTATE: s_nxt.rdata = s_r.rotate;
            GR_READ_PLANE: s_nxt.rdata = s_r.read_plane;
            GR_MODE: s_nxt.rdata = s_r.gfx_mode;
            GR_MEM_MAP: s_nxt.rdata = s_r.mem_map;
            GR_DONT_CARE: s_nxt.rdata = s_r.dont_care;
            GR_BIT_MASK: s_nxt.rdata = s_r.bit_mask;
            default: s_nxt.rdata = 8'h00;
          endcase
        end
        PORT_ATTR_INDEX: s_nxt.rdata = s_r.attr_index;
        PORT_ATTR_DATA:
        begin
          if (s_r.attr_index[4:0] <= AR_PAL_LAST)
          begin
            s_nxt.rdata = s_r.attr_pal[s_r.attr_index[3:0]];
          end
          else
          begin
            case (s_r.attr_index[4:0])
              AR_MODE: s_nxt.rdata = s_r.attr_mode;
              AR_BORDER: s_nxt.rdata = s_r.border;
              AR_PLANE_EN: s_nxt.rdata = s_r.plane_en;
              AR_PAN: s_nxt.rdata = s_r.pan;
              AR_PAD: s_nxt.rdata = s_r.pad;
              default: s_nxt.rdata = 8'h00;
            endcase
          end
        end
        PORT_STATUS_MONO, PORT_STATUS_COLOR: s_nxt.attr_is_data = 1'b0; // status lives elsewhere; rearms index
        PORT_PAL_MASK: s_nxt.rdata = s_r.pal_mask;
        PORT_PAL_RINDEX:
          s_nxt.rdata = {6'h00, (s_r.pal_last == PAL_CYCLE_READ) ? PAL_STATUS_READ : PAL_STATUS_WRITE};
        PORT_PAL_WINDEX: s_nxt.rdata = s_r.pal_windex;
        PORT_PAL_DATA:
        begin
          // a read always follows the read index and moves it on after blue
          s_nxt.rdata = pick_comp(pal_host_color, s_r.pal_sub);
          s_nxt.pal_last = PAL_CYCLE_READ;
          if (s_r.pal_sub == PAL_LAST_COMP)
          begin
            s_nxt.pal_rindex = s_r.pal_rindex + 8'h01;
            s_nxt.pal_sub = 2'h0;
          end
          else
          begin
            s_nxt.pal_sub = s_r.pal_sub + 2'h1;
          end
        end
        default: ;
      endcase
    end

    // attribute pixel path: plane enables gate the pixel, padding fills the top
    attr_entry = s_r.attr_pal[i_pixel_attr & s_r.plane_en[3:0]];
    s_nxt.video_index[3:0] = attr_entry[3:0];
    s_nxt.video_index[7:6] = s_r.pad[PAD_HIGH_LSB+:2];
    if (s_r.attr_mode[AM_PAD_SELECT])
    begin
      s_nxt.video_index[5:4] = s_r.pad[PAD_LOW_LSB+:2];
    end
    else
    begin
      s_nxt.video_index[5:4] = attr_entry[5:4];
    end
    // palette pixel path, masked by the pixel read mask
    s_nxt.dac_color = pal_pixel_color;
  end

  // ==========================================================================
  // state register
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      s_r <= '0;
      s_r.bit_mask <= RST_BIT_MASK;
      s_r.pal_mask <= RST_PAL_MASK;
      s_r.pal_last <= PAL_CYCLE_WRITE;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================================
  // outputs, all taken straight from the state register
  assign o_io_rdata = s_r.rdata;
  assign o_io_rdata_valid = s_r.rdata_valid;
  assign o_compare_color = s_r.compare[3:0];
  assign o_compare_dont_care = s_r.dont_care[3:0];
  assign o_rotate_count = s_r.rotate[ROT_COUNT_LSB+:3];
  assign o_logic_function = s_r.rotate[ROT_FUNC_LSB+:2];
  assign o_read_plane = s_r.read_plane[1:0];
  assign o_write_mode = s_r.gfx_mode[GM_WRITE_MODE_LSB+:2];
  assign o_read_compare_en = s_r.gfx_mode[GM_READ_COMPARE];
  assign o_odd_even_addr = s_r.gfx_mode[GM_ODD_EVEN];
  assign o_shift_odd_even = s_r.gfx_mode[GM_SHIFT_ODD_EVEN];
  assign o_shift_256 = s_r.gfx_mode[GM_SHIFT_256];
  assign o_graphics_addr = s_r.mem_map[MM_GRAPHICS];
  assign o_chain_odd_even = s_r.mem_map[MM_CHAIN];
  assign o_memory_map = s_r.mem_map[MM_MAP_LSB+:2];
  assign o_write_bit_mask = s_r.bit_mask;
  assign o_video_enable = s_r.attr_index[AI_VIDEO_EN];
  assign o_attr_graphics = s_r.attr_mode[AM_GRAPHICS];
  assign o_attr_mono = s_r.attr_mode[AM_MONO];
  assign o_attr_line_graphics = s_r.attr_mode[AM_LINE_GFX];
  assign o_attr_blink = s_r.attr_mode[AM_BLINK];
  assign o_attr_top_pan = s_r.attr_mode[AM_TOP_PAN];
  assign o_attr_256_color = s_r.attr_mode[AM_256_COLOR];
  assign o_border_color = s_r.border;
  assign o_plane_enable = s_r.plane_en[3:0];
  assign o_status_select = s_r.plane_en[PE_STATUS_SEL_LSB+:2];
  assign o_pixel_pan = s_r.pan[3:0];
  assign o_video_index = s_r.video_index;
  assign o_dac_color = s_r.dac_color;

endmodule

/* File: rtl/vga_regs_pkg.sv */
/*
  Shared constants for the graphics, attribute and palette register bank:
  port addresses, register indices, field positions, write masks and
  reset values.
  Assumes one system clock domain and byte-wide host I/O port cycles.
*/
package vga_regs_pkg;

  // ==========================================================================
  // host i/o port addresses
  localparam logic [15:0] PORT_ATTR_INDEX = 16'h03C0;
  localparam logic [15:0] PORT_ATTR_DATA = 16'h03C1;
  localparam logic [15:0] PORT_PAL_MASK = 16'h03C6;
  localparam logic [15:0] PORT_PAL_RINDEX = 16'h03C7;
  localparam logic [15:0] PORT_PAL_WINDEX = 16'h03C8;
  localparam logic [15:0] PORT_PAL_DATA = 16'h03C9;
  localparam logic [15:0] PORT_GFX_INDEX = 16'h03CE;
  localparam logic [15:0] PORT_GFX_DATA = 16'h03CF;
  localparam logic [15:0] PORT_STATUS_MONO = 16'h03BA;
  localparam logic [15:0] PORT_STATUS_COLOR = 16'h03DA;

  // ==========================================================================
  // graphics controller indices
  localparam logic [3:0] GR_COMPARE = 4'h2;
  localparam logic [3:0] GR_ROTATE = 4'h3;
  localparam logic [3:0] GR_READ_PLANE = 4'h4;
  localparam logic [3:0] GR_MODE = 4'h5;
  localparam logic [3:0] GR_MEM_MAP = 4'h6;
  localparam logic [3:0] GR_DONT_CARE = 4'h7;
  localparam logic [3:0] GR_BIT_MASK = 4'h8;

  // ==========================================================================
  // attribute controller indices
  localparam logic [4:0] AR_PAL_LAST = 5'h0F;
  localparam logic [4:0] AR_MODE = 5'h10;
  localparam logic [4:0] AR_BORDER = 5'h11;
  localparam logic [4:0] AR_PLANE_EN = 5'h12;
  localparam logic [4:0] AR_PAN = 5'h13;
  localparam logic [4:0] AR_PAD = 5'h14;

  // ==========================================================================
  // implemented-bit masks; reserved bits read as zero
  localparam logic [7:0] MASK_COMPARE = 8'h0F;
  localparam logic [7:0] MASK_ROTATE = 8'h1F;
  localparam logic [7:0] MASK_READ_PLANE = 8'h03;
  localparam logic [7:0] MASK_GFX_MODE = 8'h7B;
  localparam logic [7:0] MASK_MEM_MAP = 8'h0F;
  localparam logic [7:0] MASK_DONT_CARE = 8'h0F;
  localparam logic [7:0] MASK_BIT_MASK = 8'hFF;
  localparam logic [7:0] MASK_ATTR_INDEX = 8'h3F;
  localparam logic [7:0] MASK_PALETTE = 8'h3F;
  localparam logic [7:0] MASK_ATTR_MODE = 8'hEF;
  localparam logic [7:0] MASK_BORDER = 8'hFF;
  localparam logic [7:0] MASK_PLANE_EN = 8'h3F;
  localparam logic [7:0] MASK_PAN = 8'h0F;
  localparam logic [7:0] MASK_PAD = 8'h0F;
  localparam logic [7:0] MASK_PAL_STATUS = 8'h03;

  // ==========================================================================
  // field positions
  localparam int ROT_COUNT_LSB = 0;
  localparam int ROT_FUNC_LSB = 3;
  localparam int GM_WRITE_MODE_LSB = 0;
  localparam int GM_READ_COMPARE = 3;
  localparam int GM_ODD_EVEN = 4;
  localparam int GM_SHIFT_ODD_EVEN = 5;
  localparam int GM_SHIFT_256 = 6;
  localparam int MM_GRAPHICS = 0;
  localparam int MM_CHAIN = 1;
  localparam int MM_MAP_LSB = 2;
  localparam int AI_VIDEO_EN = 5;
  localparam int AM_GRAPHICS = 0;
  localparam int AM_MONO = 1;
  localparam int AM_LINE_GFX = 2;
  localparam int AM_BLINK = 3;
  localparam int AM_TOP_PAN = 5;
  localparam int AM_256_COLOR = 6;
  localparam int AM_PAD_SELECT = 7;
  localparam int PE_STATUS_SEL_LSB = 4;
  localparam int PAD_LOW_LSB = 0;
  localparam int PAD_HIGH_LSB = 2;

  // ==========================================================================
  // reset values, palette geometry, status codes
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_BIT_MASK = 8'hFF;
  localparam logic [7:0] RST_PAL_MASK = 8'hFF;
  localparam int PAL_INDEX_BITS = 8;
  localparam int PAL_COMP_BITS = 6;
  localparam logic [1:0] PAL_LAST_COMP = 2'h2;
  localparam logic [1:0] PAL_STATUS_WRITE = 2'h0;
  localparam logic [1:0] PAL_STATUS_READ = 2'h3;

  typedef enum logic {PAL_CYCLE_WRITE, PAL_CYCLE_READ} pal_cycle_type;

endpackage

/* File: rtl/palette_store.sv */
/*
  Colour lookup table storage: one write port, one host read port and one
  pixel read port, each entry three 6-bit components.
  Assumes the owner sequences component bytes and writes whole entries.
*/
`timescale 1ns/1ns
module palette_store
  import vga_regs_pkg::*;
#(
  parameter int IDX_W = PAL_INDEX_BITS
)
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // write port
  input wire logic i_wr_en,
  input wire logic [IDX_W-1:0] i_wr_index,
  input wire logic [3*PAL_COMP_BITS-1:0] i_wr_color,
  // read ports
  input wire logic [IDX_W-1:0] i_host_index,
  output logic [3*PAL_COMP_BITS-1:0] o_host_color,
  input wire logic [IDX_W-1:0] i_pixel_index,
  output logic [3*PAL_COMP_BITS-1:0] o_pixel_color
);

  // ==========================================================================
  // storage
  typedef struct packed {
    logic [(1<<IDX_W)-1:0][3*PAL_COMP_BITS-1:0] mem;
  } store_type;

  store_type s_r;
  store_type s_nxt;

  if (IDX_W < 4 || IDX_W > PAL_INDEX_BITS)
  begin : g_bad_width
    $error("palette_store: IDX_W out of range");
  end

  // next-state: a single entry changes per write
  always_comb
  begin
    s_nxt = s_r;
    if (i_wr_en)
    begin
      s_nxt.mem[i_wr_index] = i_wr_color;
    end
  end

  // contents cleared at reset so reads are never undefined
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // read ports are combinational; the owner registers them
  assign o_host_color = s_r.mem[i_host_index];
  assign o_pixel_color = s_r.mem[i_pixel_index];

endmodule

/* File: sim/vga_regs_chk.sv */
/*
  Port assertions for the graphics, attribute and palette register bank.
  Assumes it is bound to every instance of the bank, on one clock domain.
*/
`timescale 1ns/1ns
module vga_regs_chk
  import vga_regs_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // host i/o port
  input wire logic [15:0] i_io_addr,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [7:0] i_io_wdata,
  input wire logic [7:0] o_io_rdata,
  input wire logic o_io_rdata_valid,
  // graphics fields
  input wire logic [3:0] o_compare_color,
  input wire logic [3:0] o_compare_dont_care,
  input wire logic [2:0] o_rotate_count,
  input wire logic [1:0] o_logic_function,
  input wire logic [1:0] o_read_plane,
  input wire logic [1:0] o_write_mode,
  input wire logic o_shift_256,
  input wire logic [1:0] o_memory_map,
  input wire logic [7:0] o_write_bit_mask
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // ==========================================================================
  // shadow of the graphics index, so each data write can be attributed
  logic [3:0] gidx_r;
  logic gdw;
  assign gdw = i_io_wr && i_io_addr == PORT_GFX_DATA;
  always_ff @(posedge i_clk or negedge i_reset_n)
    if (!i_reset_n)
      gidx_r <= 4'h0;
    else if (i_io_wr && i_io_addr == PORT_GFX_INDEX)
      gidx_r <= i_io_wdata[3:0];
  // ==========================================================================
  // a data write lands in its field one cycle later
  chk_compare_color: assert property (gdw && gidx_r == GR_COMPARE |=> o_compare_color == $past(i_io_wdata[3:0]))
    else $error("compare colour not loaded");
  chk_dont_care_load: assert property (gdw && gidx_r == GR_DONT_CARE |=> o_compare_dont_care == $past(i_io_wdata[3:0]))
    else $error("dont care field not loaded");
  chk_rotate_logic: assert property (gdw && gidx_r == GR_ROTATE |=> {o_logic_function, o_rotate_count} == $past(i_io_wdata[4:0]))
    else $error("rotate or logic field not loaded");
  chk_read_plane: assert property (gdw && gidx_r == GR_READ_PLANE |=> o_read_plane == $past(i_io_wdata[1:0]))
    else $error("read plane not loaded");
  chk_gfx_mode: assert property (gdw && gidx_r == GR_MODE |=> {o_shift_256, o_write_mode} == {$past(i_io_wdata[6]), $past(i_io_wdata[1:0])})
    else $error("graphics mode fields not loaded");
  chk_memory_map: assert property (gdw && gidx_r == GR_MEM_MAP |=> o_memory_map == $past(i_io_wdata[3:2]))
    else $error("memory window select not loaded");
  // bit mask read-back must agree with the field the datapath sees; palette status reads are well formed
  chk_mask_readback: assert property (i_io_rd && i_io_addr == PORT_GFX_DATA && gidx_r == GR_BIT_MASK |=> o_io_rdata_valid && o_io_rdata == o_write_bit_mask)
    else $error("bit mask read differs from field");
  chk_status_form: assert property (i_io_rd && i_io_addr == PORT_PAL_RINDEX |=> o_io_rdata_valid && o_io_rdata[7:2] == 6'h00 && o_io_rdata[1] == o_io_rdata[0])
    else $error("palette status malformed");
endmodule
bind vga_gfx_attr_dac_regs vga_regs_chk u_vga_regs_chk (.*);

/* File: sim/host_io_model.sv */
/*
  Host processor model issuing byte I/O port writes and reads.
  Assumes the bench pops exp_q each time read data is returned.
*/
`timescale 1ns/1ns
module host_io_model
  import vga_regs_pkg::*;
(
  // bench clock
  input wire logic i_clk,
  // host port drive
  output logic [15:0] o_io_addr,
  output logic o_io_wr,
  output logic o_io_rd,
  output logic [7:0] o_io_wdata
);
  logic [7:0] exp_q [$];
  // ==========================================================================
  // one-cycle strobe; released lines show the inverse
  task automatic cyc(input logic [15:0] a, input logic w, input logic [7:0] dat);
    @(negedge i_clk);
    o_io_addr = a;
    o_io_wdata = dat;
    o_io_wr = w;
    o_io_rd = !w;
    @(negedge i_clk);
    o_io_wr = 1'b0;
    o_io_rd = 1'b0;
    o_io_addr = ~a;
    o_io_wdata = ~dat;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] dat);
    cyc(a, 1'b1, dat);
  endtask
  // the expected byte is noted before the strobe goes out
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    cyc(a, 1'b0, ~e);
  endtask
  // index always loaded before the data port is touched
  task automatic gfx(input logic [3:0] i, input logic [7:0] dat);
    wr(PORT_GFX_INDEX, {4'h0, i});
    wr(PORT_GFX_DATA, dat);
  endtask
  // status read returns the shared port to index before each pair
  task automatic attr(input logic [4:0] i, input logic [7:0] dat, input logic [7:0] e);
    rd(PORT_STATUS_COLOR, 8'h00);
    wr(PORT_ATTR_INDEX, {3'b001, i});
    wr(PORT_ATTR_INDEX, dat);
    wr(PORT_ATTR_INDEX, {3'b001, i});
    rd(PORT_ATTR_DATA, e);
  endtask
  // idle bus from time zero
  initial
  begin
    o_io_addr = 16'h0000;
    o_io_wr = 1'b0;
    o_io_rd = 1'b0;
    o_io_wdata = 8'h00;
  end
endmodule

/* File: sim/vga_gfx_attr_dac_regs_tb.sv */
/*
  Self-checking bench for the register bank and its pixel paths.
  Assumes host_io_model drives the port and vga_regs_chk is bound.
*/
`timescale 1ns/1ns
module vga_gfx_attr_dac_regs_tb
  import vga_regs_pkg::*;
;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic [15:0] i_io_addr;
  logic i_io_wr;
  logic i_io_rd;
  logic [7:0] i_io_wdata;
  logic [7:0] o_io_rdata;
  logic o_io_rdata_valid;
  logic [3:0] i_pixel_attr = 4'h0;
  logic [7:0] i_dac_pixel = 8'h00;
  logic o_video_enable;
  logic [7:0] o_write_bit_mask;
  logic [1:0] o_read_plane;
  logic [7:0] o_video_index;
  logic [17:0] o_dac_color;
  int error_cnt = 0;
  int checked = 0;
  logic [7:0] gmask [7] = '{8'h0F, 8'h1F, 8'h03, 8'h7B, 8'h0F, 8'h0F, 8'hFF};
  logic [4:0] aidx [7] = '{5'h00, 5'h0F, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14};
  logic [7:0] amask [7] = '{8'h3F, 8'h3F, 8'hEF, 8'hFF, 8'h3F, 8'h0F, 8'h0F};
  logic [5:0] c [3];
  logic [7:0] d;
  // ==========================================================================
  // 250 MHz clock
  always #2 i_clk = ~i_clk;
  host_io_model u_host_io_model (.i_clk, .o_io_addr(i_io_addr), .o_io_wr(i_io_wr), .o_io_rd(i_io_rd),
    .o_io_wdata(i_io_wdata));
  vga_gfx_attr_dac_regs u_vga_gfx_attr_dac_regs (.i_clk, .i_reset_n, .i_io_addr, .i_io_wr, .i_io_rd,
    .i_io_wdata, .o_io_rdata, .o_io_rdata_valid, .i_pixel_attr, .i_dac_pixel, .o_compare_color(),
    .o_compare_dont_care(), .o_rotate_count(), .o_logic_function(), .o_read_plane, .o_write_mode(),
    .o_read_compare_en(), .o_odd_even_addr(), .o_shift_odd_even(), .o_shift_256(), .o_graphics_addr(),
    .o_chain_odd_even(), .o_memory_map(), .o_write_bit_mask, .o_video_enable, .o_attr_graphics(),
    .o_attr_mono(), .o_attr_line_graphics(), .o_attr_blink(), .o_attr_top_pan(), .o_attr_256_color(),
    .o_border_color(), .o_plane_enable(), .o_status_select(), .o_pixel_pan(), .o_video_index, .o_dac_color);
  // ==========================================================================
  task automatic chk(input string n, input logic [17:0] e, input logic [17:0] s);
    checked++;
    if (s !== e)
    begin
      $display("mismatch %s expected %h seen %h", n, e, s);
      error_cnt++;
    end
  endtask
  task automatic complete_run;
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // oldest note answers each read
  always @(negedge i_clk)
    if (o_io_rdata_valid === 1'b1)
      chk("read data", u_host_io_model.exp_q.pop_front(), o_io_rdata);
  // hang guard
  initial
  begin
    repeat (20000) @(posedge i_clk);
    error_cnt++;
    complete_run();
  end
  // ==========================================================================
  initial
  begin
    void'($urandom(24));
    repeat (20) @(negedge i_clk);
    i_reset_n = 1'b1;
    chk("bit mask", 18'h000FF, o_write_bit_mask);
    chk("read plane", 18'h0, o_read_plane);
    u_host_io_model.rd(PORT_PAL_MASK, 8'hFF);
    // random graphics writes, reserved bits read zero
    for (int i = 0; i < 7; i++)
    begin
      d = 8'($urandom);
      u_host_io_model.gfx(4'(i + 2), d);
      u_host_io_model.rd(PORT_GFX_DATA, d & gmask[i]);
    end
    u_host_io_model.gfx(4'hC, 8'h55);
    u_host_io_model.rd(PORT_GFX_DATA, 8'h00);
    // attribute palette ends and every control register
    for (int i = 0; i < 7; i++)
    begin
      d = 8'($urandom);
      u_host_io_model.attr(aidx[i], d, d & amask[i]);
    end
    chk("video enable", 18'h1, o_video_enable);
    // pixel path: entry 5 = 2A, padding 1101, all planes on
    u_host_io_model.attr(5'h05, 8'h2A, 8'h2A);
    u_host_io_model.attr(AR_PLANE_EN, 8'h0F, 8'h0F);
    u_host_io_model.attr(AR_PAD, 8'h0D, 8'h0D);
    u_host_io_model.attr(AR_MODE, 8'h80, 8'h80);
    i_pixel_attr = 4'h5;
    repeat (3) @(negedge i_clk);
    chk("video index pad", 18'hDA, o_video_index);
    u_host_io_model.attr(AR_MODE, 8'h00, 8'h00);
    repeat (3) @(negedge i_clk);
    chk("video index entry", 18'hEA, o_video_index);
    // palette write, status, read back
    u_host_io_model.wr(PORT_PAL_WINDEX, 8'h40);
    for (int k = 0; k < 3; k++)
    begin
      c[k] = 6'($urandom);
      u_host_io_model.wr(PORT_PAL_DATA, {2'b00, c[k]});
    end
    u_host_io_model.rd(PORT_PAL_RINDEX, 8'h00);
    u_host_io_model.wr(PORT_PAL_RINDEX, 8'h40);
    for (int k = 0; k < 3; k++)
      u_host_io_model.rd(PORT_PAL_DATA, {2'b00, c[k]});
    u_host_io_model.rd(PORT_PAL_RINDEX, 8'h03);
    u_host_io_model.rd(PORT_PAL_WINDEX, 8'h41);
    i_dac_pixel = 8'h40;
    repeat (3) @(negedge i_clk);
    chk("dac colour", {c[0], c[1], c[2]}, o_dac_color);
    repeat (4) @(negedge i_clk);
    chk("reads unanswered", 18'h0, 18'(u_host_io_model.exp_q.size()));
    complete_run();
  end
endmodule
